//--- wdg_pkg.sv
// constants and types shared by the watchdog block
// assumes a 125 MHz system clock and an APB register bus
package wdg_pkg;
  // register byte addresses
  localparam logic [11:0] CTRL_OFS  = 12'h80c;
  localparam logic [11:0] STAT_OFS  = 12'h810;
  // control register fields
  localparam int          CS_BIT    = 7;
  localparam int          PS_MSB    = 5;
  localparam int          PS_LSB    = 1;
  localparam int          SEN_BIT   = 0;
  localparam logic        CS_RST    = 1'b0;
  localparam logic        SEN_RST   = 1'b0;
  localparam logic [4:0]  PS_RST    = 5'h0b;
  localparam logic [4:0]  PS_MAX    = 5'h12;
  // status register fields
  localparam int          TO_BIT    = 0;
  localparam int          PD_BIT    = 1;
  localparam int          WATCHDOG_RESET_FLAG_BIT  = 2;
  localparam int          SLP_BIT   = 3;
  localparam logic        FLAG_RST  = 1'b1;
  // time base
  localparam int          SYS_HZ    = 125000000;
  localparam int          LF_HZ     = 31000;
  localparam int          MF_HZ     = 31250;
  localparam int          LF_DIV    = SYS_HZ / LF_HZ;
  localparam int          MF_DIV    = SYS_HZ / MF_HZ;
  localparam int          DIV_W     = 13;
  // counter: 1:32 shifted by up to 18 reaches 2^23
  localparam int          CNT_W     = 23;
  localparam logic [22:0] BASE_DIV  = 23'h000020;
  // operating modes from the configuration word
  typedef enum logic [1:0] {
    MODE_OFF   = 2'b00,
    MODE_SW    = 2'b01,
    MODE_NOSLP = 2'b10,
    MODE_ON    = 2'b11
  } wdg_mode_e;
  // device power state, one-hot
  typedef enum logic [1:0] {
    ST_AWAKE  = 2'b01,
    ST_ASLEEP = 2'b10
  } wdg_dev_e;
endpackage : wdg_pkg

//--- wdg_top.sv
// watchdog counter with sleep wake, APB slave for its registers
// assumes core events arrive as one-cycle pulses on i_sys_clk
//
// How it works
// RQ1 - awake time-out without clear resets device
// RQ2 - cs 1 picks 31.25 kHz, 0 31 kHz
// RQ3 - mode 11 always active, sleep too
// RQ4 - mode 10 active awake, off asleep
// RQ5 - mode 01 follows software enable bit
// RQ6 - mode 00 always disabled
// RQ7 - prescale n gives ratio 32 shl n
// RQ8 - reserved prescale codes act as 1:32
// RQ9 - prescale resets to code 01011
// RQ10 - clear on reset, instruction, sleep, wake, write
// RQ11 - in sleep, count restarts from zero
// RQ12 - sleep time-out wakes, never resets
// RQ13 - time-out clears three status flags
// RQ14 - cs bit7, prescale 5:1, enable bit0
// RQ15 - disabled watchdog holds count at zero
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module wdg_top #(
  // time base dividers, system cycles per oscillator tick
  parameter int LF_DIV = wdg_pkg::LF_DIV,
  parameter int MF_DIV = wdg_pkg::MF_DIV
) (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // core events and configuration
  input  wire logic [1:0]  i_mode_sel,
  input  wire logic        i_clear_wdt,
  input  wire logic        i_sleep_req,
  input  wire logic        i_wake_req,
  // device effects and status
  output logic             o_wdt_reset,
  output logic             o_wake,
  output logic             o_asleep,
  output logic             o_timeout_n,
  output logic             o_power_down_n,
  output logic             o_wdt_reset_flag_n
);

  // prescale code to terminal count, reserved codes fold to 1:32
  function automatic logic [22:0] wdg_term(input logic [4:0] ps);
    logic [4:0] n;
    n = (ps > wdg_pkg::PS_MAX) ? 5'h00 : ps; // RQ8
    return (wdg_pkg::BASE_DIV << n) - 23'h000001; // RQ7
  endfunction : wdg_term

  // control register fields
  logic                     cs_reg;
  logic [4:0]               ps_reg;
  logic                     sen_reg;
  // device state and counter
  wdg_pkg::wdg_dev_e        dev_reg;
  logic [wdg_pkg::CNT_W-1:0] cnt_reg;
  // status flags, active low
  logic                     to_n_reg;
  logic                     pd_n_reg;
  logic                     watchdog_reset_flag_n_reg;
  // bus answer registers
  logic [31:0]              prdata_reg;
  logic                     pready_reg;
  logic                     pslverr_reg;
  // event outputs
  logic                     rst_out_reg;
  logic                     wake_out_reg;
  // oscillator tick per source: 0 low, 1 medium
  wire  [1:0]               osc_tick;

  // oscillator time bases as enables from the system clock
  for (genvar g = 0; g < 2; g++) begin : g_osc
    localparam int DIVN = (g == 0) ? LF_DIV : MF_DIV;
    logic [wdg_pkg::DIV_W-1:0] div_reg;  // cycle count
    logic                      tick_reg; // one-cycle tick
    // both run always so a source switch sees a live tick
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        div_reg  <= '0;
        tick_reg <= 1'b0;
      end else if (div_reg == wdg_pkg::DIV_W'(DIVN - 1)) begin
        div_reg  <= '0;
        tick_reg <= 1'b1;
      end else begin
        div_reg  <= div_reg + 1'b1;
        tick_reg <= 1'b0;
      end
    end
    // one flop per source keeps each bit single-driven
    assign osc_tick[g] = tick_reg;
  end

  // bus decode; the write lands on the edge that samples pready
  wire bus_acc   = i_psel & i_penable & pready_reg;
  wire bus_wr    = bus_acc & i_pwrite;
  wire hit_ctrl  = (i_paddr == wdg_pkg::CTRL_OFS);
  wire hit_stat  = (i_paddr == wdg_pkg::STAT_OFS);
  wire mapped    = hit_ctrl | hit_stat;
  wire ctrl_wr   = bus_wr & hit_ctrl; // RQ10
  wire ctrl_load = ctrl_wr & i_pstrb[0];
  wire watchdog_reset_flag_set  = bus_wr & hit_stat & i_pstrb[0]
                 & i_pwdata[wdg_pkg::WATCHDOG_RESET_FLAG_BIT];

  // mode decode
  wire asleep    = (dev_reg == wdg_pkg::ST_ASLEEP);
  wire awake     = (dev_reg == wdg_pkg::ST_AWAKE);
  wire mode_on   = (i_mode_sel == wdg_pkg::MODE_ON);    // RQ3
  wire mode_nosl = (i_mode_sel == wdg_pkg::MODE_NOSLP); // RQ4
  wire mode_sw   = (i_mode_sel == wdg_pkg::MODE_SW);    // RQ5
  // mode 00 matches no term, so it is never active
  wire active    = mode_on | (mode_nosl & awake)        // RQ6
                 | (mode_sw & sen_reg);

  // counter time base and terminal count
  wire                       tick = cs_reg ? osc_tick[1]
                                           : osc_tick[0]; // RQ2
  wire [wdg_pkg::CNT_W-1:0]  term = wdg_term(ps_reg);
  wire                       at_term = (cnt_reg == term);

  // a clear in the same cycle beats the expiry
  wire timeout   = active & tick & at_term
                 & ~i_clear_wdt & ~ctrl_wr;
  wire sleep_in  = awake & i_sleep_req;
  wire wake_evt  = asleep & (i_wake_req | timeout); // RQ12
  wire cnt_clr   = i_clear_wdt | ctrl_wr | sleep_in
                 | wake_evt | ~active; // RQ10

  // control register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_reg  <= wdg_pkg::CS_RST;
      ps_reg  <= wdg_pkg::PS_RST; // RQ9
      sen_reg <= wdg_pkg::SEN_RST;
    end else if (ctrl_load) begin
      cs_reg  <= i_pwdata[wdg_pkg::CS_BIT]; // RQ14
      ps_reg  <= i_pwdata[wdg_pkg::PS_MSB:wdg_pkg::PS_LSB];
      sen_reg <= i_pwdata[wdg_pkg::SEN_BIT];
    end
  end

  // device power state
  wdg_pkg::wdg_dev_e dev_next;
  always_comb begin
    dev_next = dev_reg;
    unique case (dev_reg)
      wdg_pkg::ST_AWAKE: begin
        if (sleep_in) dev_next = wdg_pkg::ST_ASLEEP;
      end
      wdg_pkg::ST_ASLEEP: begin
        if (wake_evt) dev_next = wdg_pkg::ST_AWAKE; // RQ12
      end
      default: dev_next = wdg_pkg::ST_AWAKE; // illegal code
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) dev_reg <= wdg_pkg::ST_AWAKE;
    else          dev_reg <= dev_next;
  end

  // counter; held at zero while inactive
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0; // RQ10
    end else if (cnt_clr) begin
      cnt_reg <= '0; // RQ15 RQ11
    end else if (tick) begin
      cnt_reg <= at_term ? '0 : cnt_reg + 1'b1;
    end
  end

  // status flags; the hardware clear wins over a re-arm
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      to_n_reg   <= wdg_pkg::FLAG_RST;
      pd_n_reg   <= wdg_pkg::FLAG_RST;
      watchdog_reset_flag_n_reg <= wdg_pkg::FLAG_RST;
    end else if (timeout) begin
      to_n_reg   <= 1'b0; // RQ13
      pd_n_reg   <= 1'b0;
      watchdog_reset_flag_n_reg <= 1'b0;
    end else begin
      if (sleep_in) begin
        to_n_reg <= 1'b1;
        pd_n_reg <= 1'b0;
      end else if (i_clear_wdt) begin
        to_n_reg <= 1'b1;
        pd_n_reg <= 1'b1;
      end
      if (watchdog_reset_flag_set) watchdog_reset_flag_n_reg <= 1'b1;
    end
  end

  // event pulses: reset when awake, wake when asleep
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_out_reg  <= 1'b0;
      wake_out_reg <= 1'b0;
    end else begin
      rst_out_reg  <= timeout & awake; // RQ1
      wake_out_reg <= wake_evt;
    end
  end

  // read data mux
  wire [31:0] ctrl_rd = {24'h000000, cs_reg, 1'b0, ps_reg, sen_reg};
  wire [31:0] stat_rd = {28'h0000000, asleep, watchdog_reset_flag_n_reg,
                         pd_n_reg, to_n_reg};
  wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd
                      : hit_stat ? stat_rd : 32'h00000000;

  // one wait state: answer registered in the first access cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else if (i_psel & i_penable & ~pready_reg) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= ~mapped;
      prdata_reg  <= i_pwrite ? 32'h00000000 : rd_mux;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end
  end

  // outputs straight from flops
  assign o_prdata           = prdata_reg;
  assign o_pready           = pready_reg;
  assign o_pslverr          = pslverr_reg;
  assign o_wdt_reset        = rst_out_reg;
  assign o_wake             = wake_out_reg;
  assign o_asleep           = dev_reg[1];
  assign o_timeout_n        = to_n_reg;
  assign o_power_down_n     = pd_n_reg;
  assign o_wdt_reset_flag_n = watchdog_reset_flag_n_reg;

  // checks
  sequence s_sleep_expiry;
    asleep && timeout;
  endsequence

  sequence s_woken;
    o_wake && !o_wdt_reset && !o_asleep && cnt_reg == '0;
  endsequence

  a_reset_on_expiry: assert property ( // RQ1
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    awake && timeout |=> o_wdt_reset && !o_wake)
    else $error("awake expiry gave no reset");

  a_sleep_wakes: assert property ( // RQ12
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_sleep_expiry |=> s_woken)
    else $error("sleep expiry did not wake cleanly");

  a_tick_source: assert property ( // RQ2
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    tick |-> (cs_reg
      ? $past(g_osc[1].div_reg) == wdg_pkg::DIV_W'(MF_DIV - 1)
      : $past(g_osc[0].div_reg) == wdg_pkg::DIV_W'(LF_DIV - 1)))
    else $error("wrong oscillator drives counter");

  a_mode_active: assert property ( // RQ3
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_mode_sel == 2'b11 |-> active)
    else $error("mode 11 not active");

  a_mode_nosleep: assert property ( // RQ4
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_mode_sel == 2'b10 |-> active == o_asleep ^ 1'b1)
    else $error("mode 10 activity wrong");

  a_mode_soft: assert property ( // RQ5
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_mode_sel == 2'b01 |-> active == sen_reg)
    else $error("mode 01 ignores enable bit");

  a_mode_off: assert property ( // RQ6
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mode_sel == 2'b00)[*2] |-> cnt_reg == '0 && !o_wdt_reset)
    else $error("disabled watchdog counts");

  a_ps_reserved: assert property ( // RQ8
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    ps_reg > 5'h12 |-> term == 23'h00001f)
    else $error("reserved prescale not minimum");

  a_ps_top: assert property ( // RQ7
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    ps_reg == 5'h12 |-> term == 23'h7fffff)
    else $error("longest prescale wrong");

  a_clear_write: assert property ( // RQ10
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    ctrl_wr || i_clear_wdt |=> cnt_reg == '0)
    else $error("counter not cleared");

  a_sleep_clear: assert property ( // RQ11
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    sleep_in |=> o_asleep && cnt_reg == '0 && !o_power_down_n)
    else $error("sleep entry did not clear");

  a_flags_expiry: assert property ( // RQ13
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    timeout |=> !o_timeout_n && !o_power_down_n
            && !o_wdt_reset_flag_n)
    else $error("expiry flags not cleared");

  a_ctrl_layout: assert property ( // RQ14
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    ctrl_load |=> cs_reg == $past(i_pwdata[7])
             && ps_reg == $past(i_pwdata[5:1]))
    else $error("control fields misplaced");

  // a disabled watchdog neither counts nor fires
  a_idle_zero: assert property ( // RQ15
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    !active |=> cnt_reg == '0 && !o_wdt_reset)
    else $error("disabled watchdog not idle");

  // any wake source restarts the count
  a_wake_clear: assert property ( // RQ10
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    wake_evt |=> cnt_reg == '0 && o_wake && !o_asleep)
    else $error("wake did not clear counter");

  // exactly one wait state on every access
  a_bus_wait: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_psel && i_penable && !o_pready |=> o_pready)
    else $error("access phase got no ready");

endmodule : wdg_top

//--- wdg_core_model.sv
// core-side model: apb master plus clear, sleep and wake pulses
// assumes the watchdog answers on apb with its own pready
`timescale 1ns/1ps
module wdg_core_model (
  // clock
  input  wire logic        i_sys_clk,
  // apb master side
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [11:0]      o_paddr,
  output logic [31:0]      o_pwdata,
  output logic [3:0]       o_pstrb,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  // core events
  output logic [1:0]       o_mode_sel,
  output logic             o_clear_wdt,
  output logic             o_sleep_req,
  output logic             o_wake_req
);
  // idle values at time zero
  initial begin
    {o_psel, o_penable, o_pwrite, o_clear_wdt} = '0;
    {o_sleep_req, o_wake_req} = '0;
    o_paddr    = 12'h000;
    o_pwdata   = 32'h0;
    o_pstrb    = 4'h0;
    o_mode_sel = 2'b00;
  end
  // one transfer; held until pready seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic err);
    @(posedge i_sys_clk);
    o_psel    <= 1'b1;
    o_pwrite  <= wr;
    o_paddr   <= a;
    o_pwdata  <= d;
    o_pstrb   <= s;
    @(posedge i_sys_clk);
    o_penable <= 1'b1;
    @(posedge i_sys_clk);
    // no fixed wait: only the bench timeout ends a stuck access
    while (i_pready !== 1'b1) begin
      @(posedge i_sys_clk);
    end
    rd = i_prdata;
    err = i_pslverr;
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    // released data lines must not look valid
    o_pwdata  <= ~d;
  endtask : apb
  // one-cycle event pulse: 0 clear, 1 sleep, 2 wake
  task automatic pulse(input int k);
    @(posedge i_sys_clk);
    o_clear_wdt <= (k == 0);
    o_sleep_req <= (k == 1);
    o_wake_req  <= (k == 2);
    @(posedge i_sys_clk);
    {o_clear_wdt, o_sleep_req, o_wake_req} <= '0;
  endtask : pulse
  // configuration word change, seen from the next edge
  task automatic set_mode(input logic [1:0] m);
    @(posedge i_sys_clk);
    o_mode_sel <= m;
  endtask : set_mode
endmodule : wdg_core_model

//--- watchdog_timer_with_sleep_wake_test.sv
// self-checking bench for the watchdog block
// assumes wdg_core_model drives every dut input except clock and reset, which the bench drives
`timescale 1ns/1ps
module watchdog_timer_with_sleep_wake_test;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, clr, slp, wk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [1:0]  mode;
  logic        rst_o, wake_o, asleep, to_n, pd_n, watchdog_reset_flag_n, err;
  int          fail_count = 0;
  int          n_checks   = 0;
  int          cyc        = 0;
  int          n;
  int          s;
  logic [7:0]  w;
  // short dividers keep every expiry inside the run budget
  localparam int LF_N = 126;
  localparam int MF_N = 125;
  // 8 ns period
  always #4 sys_clk = ~sys_clk;
  wdg_core_model core_u (.i_sys_clk(sys_clk), .o_psel(psel),
    .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
    .o_pwdata(pwdata), .o_pstrb(pstrb), .i_prdata(prdata),
    .i_pready(pready), .i_pslverr(pslverr), .o_mode_sel(mode),
    .o_clear_wdt(clr), .o_sleep_req(slp), .o_wake_req(wk));
  wdg_top #(.LF_DIV(LF_N), .MF_DIV(MF_N)) dut_u (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_mode_sel(mode),
    .i_clear_wdt(clr), .i_sleep_req(slp), .i_wake_req(wk),
    .o_wdt_reset(rst_o), .o_wake(wake_o), .o_asleep(asleep),
    .o_timeout_n(to_n), .o_power_down_n(pd_n),
    .o_wdt_reset_flag_n(watchdog_reset_flag_n));
  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // readback of a control write: bit 6 is not implemented
  function automatic logic [31:0] ctrl_exp(input logic [7:0] v);
    return {24'h0, v & 8'hbf};
  endfunction : ctrl_exp
  // expected delay window, in negedges after a clear
  function automatic bit in_win(input int cnt, input int dv,
                                input logic [4:0] ps);
    int t;
    t = 32 << ((ps > wdg_pkg::PS_MAX) ? 5'h00 : ps);
    return cnt >= (t - 1) * dv + 2 && cnt <= t * dv + 1;
  endfunction : in_win
  // negedges until a reset (0) or wake (1) pulse, strays counted
  task automatic wait_evt(input bit sel, output int cnt,
                          output int stray);
    cnt = 0;
    stray = 0;
    while ((sel ? wake_o : rst_o) !== 1'b1 && cnt < 40000) begin
      @(negedge sys_clk);
      cnt++;
      if ((sel ? rst_o : wake_o) === 1'b1) stray++;
    end
  endtask : wait_evt
  // reset pulses seen over a number of cycles
  task automatic count_rst(input int len, output int cnt);
    cnt = 0;
    repeat (len) begin
      @(negedge sys_clk);
      if (rst_o === 1'b1) cnt++;
    end
  endtask : count_rst
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // hang guard, all the expiry tests need about 88k cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 95000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h7f21e686));
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    core_u.apb(0, wdg_pkg::CTRL_OFS, 0, 0, rd, err);
    check(rd, 32'h16);
    core_u.apb(0, wdg_pkg::STAT_OFS, 0, 0, rd, err);
    check(rd, 32'h7);
    core_u.apb(0, 12'h400, 0, 0, rd, err);
    check({31'h0, err}, 32'h1);
    $display("test reset values done");
    // random control writes, then a write with no strobe
    for (int i = 0; i < 8; i++) begin
      w = 8'($urandom);
      core_u.apb(1, wdg_pkg::CTRL_OFS, {24'h0, w}, 4'h1, rd, err);
      core_u.apb(0, wdg_pkg::CTRL_OFS, 0, 0, rd, err);
      check(rd, ctrl_exp(w));
    end
    core_u.apb(1, wdg_pkg::CTRL_OFS, 32'h0, 4'h0, rd, err);
    core_u.apb(0, wdg_pkg::CTRL_OFS, 0, 0, rd, err);
    check(rd, ctrl_exp(w));
    $display("test control field map done");
    // sleep entry and other wake source, mode off in sleep
    core_u.set_mode(2'b10);
    core_u.pulse(2);
    @(negedge sys_clk);
    check({30'h0, wake_o, asleep}, 32'h0);
    core_u.pulse(1);
    @(negedge sys_clk);
    check({30'h0, wake_o, asleep}, 32'h1);
    core_u.apb(0, wdg_pkg::STAT_OFS, 0, 0, rd, err);
    check(rd & 32'hb, 32'h9);
    core_u.pulse(2);
    @(negedge sys_clk);
    check({30'h0, wake_o, asleep}, 32'h2);
    $display("test sleep and wake done");
    // awake expiry at prescale 00011 on the 31.25 kHz base
    core_u.set_mode(2'b11);
    core_u.apb(1, wdg_pkg::CTRL_OFS, 32'h86, 4'h1, rd, err);
    count_rst(2000, n);
    check(n, 0);
    core_u.pulse(0);
    wait_evt(0, n, s);
    // tick phase is unknown, so the window is one tick wide
    check({31'h0, in_win(n, MF_N, 5'h03)}, 32'h1);
    check(s, 0);
    core_u.apb(0, wdg_pkg::STAT_OFS, 0, 0, rd, err);
    check(rd, 32'h0);
    core_u.pulse(0);
    core_u.apb(1, wdg_pkg::STAT_OFS, 32'h4, 4'h1, rd, err);
    core_u.apb(0, wdg_pkg::STAT_OFS, 0, 0, rd, err);
    check(rd, 32'h7);
    $display("test awake expiry done");
    // same prescale on the 31 kHz base, then a reserved code
    core_u.apb(1, wdg_pkg::CTRL_OFS, 32'h06, 4'h1, rd, err);
    core_u.pulse(0);
    wait_evt(0, n, s);
    check({31'h0, in_win(n, LF_N, 5'h03)}, 32'h1);
    core_u.apb(1, wdg_pkg::CTRL_OFS, 32'hbe, 4'h1, rd, err);
    core_u.pulse(0);
    wait_evt(0, n, s);
    check({31'h0, in_win(n, MF_N, 5'h1f)}, 32'h1);
    $display("test time base and reserved code done");
    // sleep expiry wakes instead of resetting, flags record it
    core_u.pulse(0);
    core_u.apb(1, wdg_pkg::STAT_OFS, 32'h4, 4'h1, rd, err);
    core_u.pulse(1);
    wait_evt(1, n, s);
    check({31'h0, in_win(n, MF_N, 5'h1f)}, 32'h1);
    check(s, 0);
    core_u.apb(0, wdg_pkg::STAT_OFS, 0, 0, rd, err);
    check(rd, 32'h0);
    $display("test sleep expiry done");
    // software enable: one expiry with the bit set, none without
    core_u.set_mode(2'b01);
    core_u.apb(1, wdg_pkg::CTRL_OFS, 32'hbf, 4'h1, rd, err);
    count_rst(4200, n);
    check(n, 1);
    core_u.apb(1, wdg_pkg::CTRL_OFS, 32'hbe, 4'h1, rd, err);
    count_rst(4200, n);
    check(n, 0);
    // mode off ignores a set enable bit
    core_u.set_mode(2'b00);
    core_u.apb(1, wdg_pkg::CTRL_OFS, 32'hbf, 4'h1, rd, err);
    count_rst(4200, n);
    check(n, 0);
    $display("test enable and off modes done");
    test_done();
  end
endmodule : watchdog_timer_with_sleep_wake_test
